/* File: pkg/serial_core_cfg.svh */
// Constants of the serial core: mode codes, register reset values, field widths.
// Assumes inclusion by bare name from the package and the design file.
`ifndef SERIAL_CORE_CFG_SVH
`define SERIAL_CORE_CFG_SVH
`define MODE_W 3
`define MODE_USART_EXT 3'h0
`define MODE_USART_INT 3'h1
`define MODE_SPI_SLAVE 3'h2
`define MODE_SPI_MASTER 3'h3
`define MODE_I2C_SLAVE 3'h4
`define MODE_I2C_MASTER 3'h5
`define BAUD_W 16
`define BAUD_RESET 16'h0000
`define DBG_RESET 1'b0
`define ADDR_W 8
`define ADDR_RESET 8'h00
`define MIN_PULSE_W 8
`define MIN_PULSE_RESET 8'h00
`define SAMPLE_SEL_W 3
`define SAMPLE_SEL_RESET 3'h0
`define IR_HIGH_SLOTS 4'h3
`define IR_SLOTS_PER_BIT 5'h10
`define FIFO_DEPTH 16
`define BYTE_W 8
`endif

/* File: pkg/serial_core_pkg.sv */
// Types shared by the serial core.
// Assumes the constants header is on the include path.
`include "serial_core_cfg.svh"
package serial_core_pkg;
	typedef enum logic [2:0] {
		usart_ext = `MODE_USART_EXT,
		usart_int = `MODE_USART_INT,
		spi_slave = `MODE_SPI_SLAVE,
		spi_master = `MODE_SPI_MASTER,
		i2c_slave = `MODE_I2C_SLAVE,
		i2c_master = `MODE_I2C_MASTER
	} op_mode_t;
	typedef struct packed {
		logic [`MODE_W-1:0] mode;
		logic [`BAUD_W-1:0] baud;
		logic [`SAMPLE_SEL_W-1:0] sample_rate_select;
		logic [`MIN_PULSE_W-1:0] rx_min_pulse_length;
		logic [`ADDR_W-1:0] match_addr;
		logic ir_enable;
	} cfg_t;
	typedef struct packed {
		logic tick_div1;
		logic tick_div2;
		logic tick_div16;
	} baud_ticks_t;
endpackage

/* File: rtl/byte_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk, // clock
	input wire logic reset, // async reset
	input wire logic flush, // clears contents
	input wire logic [WIDTH-1:0] in_data, // write data
	input wire logic in_valid, // write request
	output logic in_ready, // not full
	output logic [WIDTH-1:0] out_data, // head word
	output logic out_valid, // not empty
	input wire logic out_ready // consumer takes head
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic do_wr, do_rd;
	logic next_in_ready;
	always_comb begin
		out_valid = wr_ptr != rd_ptr;
		out_data = mem[rd_ptr[AW-1:0]];
		do_wr = in_valid && in_ready;
		do_rd = out_valid && out_ready;
		next_wr_ptr = flush ? '0 : wr_ptr + (AW+1)'(do_wr);
		next_rd_ptr = flush ? '0 : rd_ptr + (AW+1)'(do_rd);
		// Registered so the not-full flag leaves the block from a flop
		next_in_ready = (next_wr_ptr - next_rd_ptr) != (AW+1)'(DEPTH);
	end
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			in_ready <= 1'b1;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			in_ready <= next_in_ready;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (do_wr) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end
endmodule // byte_fifo

/* File: rtl/serial_core.sv */
// Serial core: role selection, enable, soft reset, baud generator, IR coding, address match.
// Assumes synchronous inputs, register writes presented as byte-enabled words.
// Behaviour
// (RULE_01) Mode field picks USART, SPI or I2C role
// (RULE_02) Enable bit starts and stops the core
// (RULE_03) Soft reset restores registers except debug
// (RULE_04) Baud rate from divider and reference
// (RULE_05) Reference is core or external clock
// (RULE_06) Async: transmit /16, receive /1 ticks
// (RULE_07) Sync roles use the /2 tick
// (RULE_08) Tick choice follows mode automatically
// (RULE_09) Address comparison for SPI and I2C roles
// (RULE_10) IR zero is 3/16-bit high pulse
// (RULE_11) Software sets 16x sampling before IR
// (RULE_12) Byte, halfword and word writes accepted
// (RULE_13) Enable-protected registers locked while enabled
// (RULE_14) Protected registers ignore writes under protection
// (RULE_15) IR pulse accepted at minimum length; the code accepts only pulses longer than rx_min_pulse_length
// (RULE_16) Soft reset bit self-clears when done
`timescale 1ns/1ps
`include "serial_core_cfg.svh"
module serial_core #(
	parameter int BAUD_W = `BAUD_W,
	parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
	input wire logic sys_clk, // 40 MHz clock
	input wire logic reset, // async active-high reset
	input wire logic ext_clk_tick, // external reference enable pulse
	input wire logic [1:0] reg_sel, // 0 control, 1 baud, 2 addr/min pulse, 3 debug
	input wire logic [31:0] reg_wdata, // write data
	input wire logic [3:0] reg_be, // byte enables
	input wire logic reg_write, // write strobe
	input wire logic write_protect, // access protection active
	input wire logic [7:0] tx_data, // transmit byte
	input wire logic tx_valid, // transmit byte offered
	output logic tx_ready, // FIFO can take a byte
	input wire logic rx_line, // serial receive line
	input wire logic [7:0] rx_addr, // address seen on SPI/I2C line
	input wire logic rx_addr_valid, // address strobe
	output logic tx_line, // serial / IR transmit line
	output logic rx_bit, // decoded receive bit
	output logic rx_bit_valid, // decoded bit strobe
	output logic addr_match, // address compare hit
	output logic enabled, // core enabled
	output logic soft_reset_busy, // soft reset bit readback
	output logic serial_tick, // selected engine tick
	output logic debug_run // debug control readback
);
	localparam int REG_CTRL = 0;
	localparam int REG_BAUD = 1;
	localparam int REG_ADDR = 2;
	localparam int REG_DBG = 3;
	// Control register bits: 0 soft reset, 1 enable, 4:2 mode, 7 ir, 15:13 sample rate
	serial_core_pkg::cfg_t cfg, next_cfg;
	serial_core_pkg::baud_ticks_t ticks;
	logic en, next_en, srst, next_srst, dbg, next_dbg;
	logic [BAUD_W-1:0] baud_cnt, next_baud_cnt;
	logic [3:0] div16_cnt, next_div16_cnt;
	logic div2_ph, next_div2_ph;
	logic ref_tick, tick_sel;
	logic [7:0] fifo_data;
	logic fifo_valid, fifo_take;
	logic [3:0] slot, next_slot;
	logic [8:0] tx_shift, next_tx_shift;
	logic [3:0] tx_bits, next_tx_bits;
	logic [7:0] rx_width, next_rx_width;
	logic rx_hit, next_rx_hit;
	logic rx_prev, next_rx_prev;
	logic [3:0] rx_slot, next_rx_slot;
	logic o_tx, next_o_tx, o_rxb, next_o_rxb, o_rxv, next_o_rxv, o_match, next_o_match;

	function automatic logic is_sync_role(input logic [2:0] m);
		return m != `MODE_USART_EXT && m != `MODE_USART_INT;
	endfunction

	function automatic logic [7:0] merge_byte(input logic [7:0] old, input int lane);
		return reg_be[lane] ? reg_wdata[lane*8 +: 8] : old;
	endfunction

	// Register file
	always_comb begin
		logic [31:0] w;
		logic [31:0] c;
		w = '0;
		c = '0;
		next_cfg = cfg;
		next_en = en;
		next_srst = 1'b0; // see (RULE_16)
		next_dbg = dbg;
		c = {16'h0000, cfg.sample_rate_select, 5'h00, cfg.ir_enable, 2'b00, cfg.mode, en, srst};
		if (reg_write && !write_protect) begin // see (RULE_14)
			unique case (reg_sel)
				2'(REG_CTRL): begin
					for (int i = 0; i < 4; i++) begin
						w[i*8 +: 8] = merge_byte(c[i*8 +: 8], i); // see (RULE_12)
					end
					next_en = w[1]; // see (RULE_02)
					if (!en) begin // see (RULE_13)
						next_cfg.mode = w[4:2]; // see (RULE_01)
						next_cfg.ir_enable = w[7];
						next_cfg.sample_rate_select = w[15:13];
					end
					if (w[0]) begin
						next_srst = 1'b1;
					end
				end
				2'(REG_BAUD): begin
					if (!en) begin // see (RULE_13)
						w[15:0] = cfg.baud;
						for (int i = 0; i < 2; i++) begin
							w[i*8 +: 8] = merge_byte(cfg.baud[i*8 +: 8], i); // see (RULE_12)
						end
						next_cfg.baud = w[BAUD_W-1:0];
					end
				end
				2'(REG_ADDR): begin
					next_cfg.match_addr = merge_byte(cfg.match_addr, 0);
					if (!en) begin // see (RULE_13)
						next_cfg.rx_min_pulse_length = merge_byte(cfg.rx_min_pulse_length, 1);
					end
				end
				2'(REG_DBG): begin
					if (reg_be[0]) begin
						next_dbg = reg_wdata[0];
					end
				end
			endcase
		end
		if (srst) begin // see (RULE_03)
			next_cfg = '{`MODE_USART_EXT, `BAUD_RESET, `SAMPLE_SEL_RESET, `MIN_PULSE_RESET,
				`ADDR_RESET, 1'b0};
			next_en = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cfg <= '{`MODE_USART_EXT, `BAUD_RESET, `SAMPLE_SEL_RESET, `MIN_PULSE_RESET,
				`ADDR_RESET, 1'b0};
			en <= 1'b0;
			srst <= 1'b0;
			dbg <= `DBG_RESET;
		end else begin
			cfg <= next_cfg;
			en <= next_en;
			srst <= next_srst;
			dbg <= next_dbg;
		end
	end

	// Baud generator: period is baud+1 reference ticks
	always_comb begin
		ref_tick = (cfg.mode == `MODE_USART_EXT) ? ext_clk_tick : 1'b1; // see (RULE_05)
		next_baud_cnt = baud_cnt;
		next_div16_cnt = div16_cnt;
		next_div2_ph = div2_ph;
		ticks.tick_div1 = 1'b0;
		if (!en) begin
			next_baud_cnt = '0;
			next_div16_cnt = '0;
			next_div2_ph = 1'b0;
		end else if (ref_tick) begin
			if (baud_cnt >= cfg.baud) begin // see (RULE_04)
				next_baud_cnt = '0;
				ticks.tick_div1 = 1'b1;
				next_div16_cnt = div16_cnt + 4'h1;
				next_div2_ph = !div2_ph;
			end else begin
				next_baud_cnt = baud_cnt + BAUD_W'(1);
			end
		end
		ticks.tick_div2 = ticks.tick_div1 && div2_ph;
		ticks.tick_div16 = ticks.tick_div1 && (div16_cnt == 4'hF);
		// Async roles bit-time on /16, sample on /1; sync roles on /2
		tick_sel = is_sync_role(cfg.mode) ? ticks.tick_div2 : ticks.tick_div16; // see (RULE_06)
	end // see (RULE_07) (RULE_08)

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			baud_cnt <= '0;
			div16_cnt <= 4'h0;
			div2_ph <= 1'b0;
		end else begin
			baud_cnt <= next_baud_cnt;
			div16_cnt <= next_div16_cnt;
			div2_ph <= next_div2_ph;
		end
	end

	byte_fifo #(.WIDTH(`BYTE_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.sys_clk(sys_clk),
		.reset(reset),
		.flush(srst),
		.in_data(tx_data),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_take)
	);

	// Transmitter: start bit, 8 data bits LSB first; idle high on the plain line, idle low with IR
	always_comb begin
		fifo_take = en && !is_sync_role(cfg.mode) && tx_bits == 4'h0 && fifo_valid;
		next_tx_shift = tx_shift;
		next_tx_bits = tx_bits;
		next_slot = slot;
		next_o_tx = o_tx;
		if (!en) begin
			next_tx_bits = 4'h0;
			next_slot = 4'h0;
			next_o_tx = cfg.ir_enable ? 1'b0 : 1'b1;
		end else if (fifo_take) begin
			next_tx_shift = {fifo_data, 1'b0};
			next_tx_bits = 4'h9;
			next_slot = 4'h0;
		end else if (tx_bits != 4'h0 && ticks.tick_div1) begin
			next_slot = slot + 4'h1;
			if (cfg.ir_enable) begin
				// Zero bit: high for the first 3 of 16 slots; one bit: no pulse
				next_o_tx = !tx_shift[0] && (slot < `IR_HIGH_SLOTS); // see (RULE_10) (RULE_11)
			end else begin
				next_o_tx = tx_shift[0];
			end
			if (slot == 4'(`IR_SLOTS_PER_BIT - 5'h01)) begin
				next_tx_shift = {1'b1, tx_shift[8:1]};
				next_tx_bits = tx_bits - 4'h1;
			end
		end else if (tx_bits == 4'h0) begin
			next_o_tx = cfg.ir_enable ? 1'b0 : 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			tx_shift <= 9'h1FF;
			tx_bits <= 4'h0;
			slot <= 4'h0;
			o_tx <= 1'b1;
		end else begin
			tx_shift <= next_tx_shift;
			tx_bits <= next_tx_bits;
			slot <= next_slot;
			o_tx <= next_o_tx;
		end
	end

	// IR receive decoder and address compare
	always_comb begin
		next_rx_prev = rx_line;
		next_rx_width = rx_width;
		next_rx_hit = rx_hit;
		next_rx_slot = rx_slot;
		next_o_rxb = o_rxb;
		next_o_rxv = 1'b0;
		next_o_match = o_match;
		// Width counts high cycles, the current one included
		if (rx_line) begin
			if (!rx_prev) begin
				next_rx_width = 8'h01;
			end else if (rx_width != 8'hFF) begin
				next_rx_width = rx_width + 8'h01;
			end
		end
		if (en && cfg.ir_enable) begin
			if (rx_line && !rx_prev) begin
				// Bit window restarts at every pulse start
				next_rx_slot = 4'h0;
			end else if (ticks.tick_div1) begin
				next_rx_slot = rx_slot + 4'h1;
				if (rx_slot == 4'h7) begin
					next_o_rxb = !rx_hit; // see (RULE_15)
					next_o_rxv = 1'b1;
					next_rx_hit = 1'b0;
				end
			end
		end
		// Acceptance after the readout clear, so a hit in that cycle is kept
		if (rx_line && next_rx_width > cfg.rx_min_pulse_length) begin // see (RULE_15)
			next_rx_hit = 1'b1;
		end
		if (en && is_sync_role(cfg.mode) && rx_addr_valid) begin
			next_o_match = rx_addr == cfg.match_addr; // see (RULE_09)
		end
		if (!en) begin
			next_o_match = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rx_prev <= 1'b0;
			rx_width <= 8'h00;
			rx_hit <= 1'b0;
			rx_slot <= 4'h0;
			o_rxb <= 1'b1;
			o_rxv <= 1'b0;
			o_match <= 1'b0;
			serial_tick <= 1'b0;
		end else begin
			rx_prev <= next_rx_prev;
			rx_width <= next_rx_width;
			rx_hit <= next_rx_hit;
			rx_slot <= next_rx_slot;
			o_rxb <= next_o_rxb;
			o_rxv <= next_o_rxv;
			o_match <= next_o_match;
			serial_tick <= tick_sel;
		end
	end

	assign tx_line = o_tx;
	assign rx_bit = o_rxb;
	assign rx_bit_valid = o_rxv;
	assign addr_match = o_match;
	assign enabled = en;
	assign soft_reset_busy = srst;
	assign debug_run = dbg;
endmodule // serial_core

/* File: verif/serial_core_monitor.sv */
// Concurrent checks on the serial core ports.
// Assumes one clock domain; bound onto every serial_core instance.
`timescale 1ns/1ps
module serial_core_monitor #(
	parameter int BAUD_W = 16,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic sys_clk, // clock
	input wire logic reset, // async reset
	input wire logic [1:0] reg_sel, // register index
	input wire logic [31:0] reg_wdata, // write data
	input wire logic [3:0] reg_be, // byte enables
	input wire logic reg_write, // write strobe
	input wire logic write_protect, // protection active
	input wire logic tx_ready, // FIFO not full
	input wire logic rx_bit_valid, // decoded bit strobe
	input wire logic addr_match, // address hit
	input wire logic enabled, // core enabled
	input wire logic soft_reset_busy, // soft reset readback
	input wire logic serial_tick, // engine tick
	input wire logic debug_run // debug readback
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	logic ctl_wr;
	assign ctl_wr = reg_write && !write_protect && reg_sel == 2'h0 && reg_be[0];
	sequence reset_done_seq;
		!soft_reset_busy && !enabled && tx_ready;
	endsequence
	sequence reset_steps_seq;
		soft_reset_busy ##1 reset_done_seq;
	endsequence
	enable_take_a: assert property (
		ctl_wr && !reg_wdata[0] && !soft_reset_busy |=> enabled == $past(reg_wdata[1]))
		else $error("enable bit not taken");
	protect_hold_a: assert property (
		write_protect && !soft_reset_busy |=> $stable(enabled))
		else $error("enable changed under protection");
	soft_reset_a: assert property (
		ctl_wr && reg_wdata[0] |=> reset_steps_seq)
		else $error("soft reset sequence wrong");
	debug_keep_a: assert property (
		soft_reset_busy && !(reg_write && reg_sel == 2'h3) |=> $stable(debug_run))
		else $error("debug bit lost in soft reset");
	debug_write_a: assert property (
		reg_write && !write_protect && reg_sel == 2'h3 && reg_be[0]
		|=> debug_run == $past(reg_wdata[0]))
		else $error("debug byte lane not written");
	match_off_a: assert property (
		!enabled [*2] |-> !addr_match)
		else $error("address hit while disabled");
	tick_space_a: assert property (
		serial_tick |=> !serial_tick)
		else $error("engine ticks too close");
	rx_pulse_a: assert property (
		rx_bit_valid |=> !rx_bit_valid [*4])
		else $error("decoded bit strobe repeated");
endmodule // serial_core_monitor
bind serial_core serial_core_monitor #(.BAUD_W(BAUD_W), .FIFO_DEPTH(FIFO_DEPTH)) mon (
	.sys_clk(sys_clk), .reset(reset), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
	.reg_be(reg_be), .reg_write(reg_write), .write_protect(write_protect),
	.tx_ready(tx_ready), .rx_bit_valid(rx_bit_valid), .addr_match(addr_match),
	.enabled(enabled), .soft_reset_busy(soft_reset_busy), .serial_tick(serial_tick),
	.debug_run(debug_run));

/* File: verif/serial_peer.sv */
// Far-side serial device: IR pulses, line addresses, external reference ticks.
// Assumes the bench calls its tasks from a procedural thread.
`timescale 1ns/1ps
module serial_peer (
	input wire logic sys_clk, // clock
	output logic ext_clk_tick, // reference tick every 4 cycles
	output logic rx_line, // IR line, idle low
	output logic [7:0] rx_addr, // address seen on the line
	output logic rx_addr_valid // address strobe
);
	logic [1:0] div = 2'h0;
	initial begin
		rx_line = 1'b0;
		rx_addr = 8'h00;
		rx_addr_valid = 1'b0;
	end
	always @(negedge sys_clk) begin
		div <= div + 2'h1;
		ext_clk_tick <= (div == 2'h3);
	end
	task automatic pulse(input int len);
		@(negedge sys_clk);
		rx_line = 1'b1;
		repeat (len) @(negedge sys_clk);
		rx_line = 1'b0;
	endtask
	task automatic send_addr(input logic [7:0] a);
		@(negedge sys_clk);
		rx_addr = a;
		rx_addr_valid = 1'b1;
		@(negedge sys_clk);
		rx_addr = ~a; // Released bus shows no stale value
		rx_addr_valid = 1'b0;
	endtask
endmodule // serial_peer

/* File: verif/tb_top.sv */
// Self-checking bench for the serial core.
// Assumes core, FIFO, peer model and checker are compiled first.
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [1:0] reg_sel = 2'h0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic [3:0] reg_be = 4'h0;
	logic reg_write = 1'b0;
	logic write_protect = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic tx_valid = 1'b0;
	logic tx_ready, ext_clk_tick, rx_line, rx_addr_valid, tx_line, rx_bit, rx_bit_valid;
	logic addr_match, enabled, soft_reset_busy, serial_tick, debug_run, bad;
	logic [7:0] rx_addr;
	int err_count = 0;
	int checks_done = 0;
	int n;
	always #12.5 sys_clk = ~sys_clk;
	serial_core dut (.sys_clk(sys_clk), .reset(reset), .ext_clk_tick(ext_clk_tick),
		.reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_be(reg_be), .reg_write(reg_write),
		.write_protect(write_protect), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_line(rx_line), .rx_addr(rx_addr),
		.rx_addr_valid(rx_addr_valid), .tx_line(tx_line), .rx_bit(rx_bit),
		.rx_bit_valid(rx_bit_valid), .addr_match(addr_match), .enabled(enabled),
		.soft_reset_busy(soft_reset_busy), .serial_tick(serial_tick), .debug_run(debug_run));
	serial_peer peer (.sys_clk(sys_clk), .ext_clk_tick(ext_clk_tick), .rx_line(rx_line),
		.rx_addr(rx_addr), .rx_addr_valid(rx_addr_valid));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic wr(input logic [1:0] s, input logic [31:0] d, input logic [3:0] be);
		@(negedge sys_clk);
		reg_sel = s;
		reg_wdata = d;
		reg_be = be;
		reg_write = 1'b1;
		@(negedge sys_clk);
		reg_write = 1'b0;
	endtask
	task automatic push(input logic [7:0] d);
		@(negedge sys_clk);
		tx_data = d;
		tx_valid = 1'b1;
		@(negedge sys_clk);
		tx_valid = 1'b0;
	endtask
	// Cycles between two engine ticks
	task automatic gap(output int c);
		c = 0;
		while (serial_tick !== 1'b1 && c < 300) begin
			@(negedge sys_clk);
			c++;
		end
		c = 0;
		do begin
			@(negedge sys_clk);
			c++;
		end while (serial_tick !== 1'b1 && c < 300);
	endtask
	function automatic logic [31:0] cw(input logic [2:0] m, input logic en, input logic ir);
		return {24'h00_0000, ir, 2'b00, m, en, 1'b0};
	endfunction
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		wrap_up;
	end
	initial begin
		repeat (12) @(negedge sys_clk);
		reset = 1'b0;
		chk({enabled, tx_line, tx_ready, soft_reset_busy, debug_run}, 5'b01100);
		wr(2'h1, 32'h0000_0000, 4'hF);
		for (int m = 0; m < 6; m++) begin
			wr(2'h0, cw(m[2:0], 1'b1, 1'b0), 4'h1);
			gap(n);
			chk(n, m == 0 ? 64 : (m == 1 ? 16 : 2));
			wr(2'h0, 32'h0000_0000, 4'h1);
		end
		wr(2'h0, cw(3'h3, 1'b1, 1'b0), 4'h1);
		wr(2'h0, cw(3'h1, 1'b1, 1'b0), 4'h1);
		wr(2'h1, 32'h0000_0005, 4'h3);
		gap(n);
		chk(n, 2);
		wr(2'h0, 32'h0000_0000, 4'h1);
		wr(2'h1, 32'h0000_0301, 4'h1);
		wr(2'h0, cw(3'h1, 1'b1, 1'b0), 4'h1);
		gap(n);
		chk(n, 32);
		wr(2'h0, 32'h0000_0000, 4'h1);
		write_protect = 1'b1;
		wr(2'h0, cw(3'h3, 1'b1, 1'b0), 4'h1);
		write_protect = 1'b0;
		chk(enabled, 1'b0);
		wr(2'h0, cw(3'h3, 1'b1, 1'b0), 4'h0);
		chk(enabled, 1'b0);
		wr(2'h3, 32'h0000_0001, 4'h1);
		repeat (16) push(8'hA5);
		chk(tx_ready, 1'b0);
		wr(2'h0, cw(3'h4, 1'b1, 1'b0), 4'h1);
		wr(2'h2, 32'h0000_005A, 4'h1);
		peer.send_addr(8'h5A);
		chk(addr_match, 1'b1);
		peer.send_addr(8'h11);
		chk(addr_match, 1'b0);
		wr(2'h0, 32'h0000_0001, 4'h1);
		chk(soft_reset_busy, 1'b1);
		@(negedge sys_clk);
		chk({soft_reset_busy, enabled, tx_ready, debug_run}, 4'b0011);
		wr(2'h2, 32'h0000_0300, 4'h2);
		wr(2'h0, cw(3'h1, 1'b1, 1'b1), 4'h1);
		repeat (2) @(negedge sys_clk);
		push(8'h00);
		n = 0;
		while (tx_line !== 1'b1 && n < 100) begin
			@(negedge sys_clk);
			n++;
		end
		n = 0;
		while (tx_line === 1'b1 && n < 100) begin
			@(negedge sys_clk);
			n++;
		end
		chk(n, 3);
		repeat (200) @(negedge sys_clk);
		peer.pulse(4);
		n = 0;
		while (rx_bit_valid !== 1'b1 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		chk({rx_bit_valid, rx_bit}, 2'b10);
		repeat (30) @(negedge sys_clk);
		peer.pulse(3);
		bad = 1'b0;
		repeat (20) begin
			@(negedge sys_clk);
			if (rx_bit_valid === 1'b1 && rx_bit === 1'b0) bad = 1'b1;
		end
		chk(bad, 1'b0);
		wrap_up;
	end
endmodule // tb_top
